// ---- hdl/ptsp_pin_ctrl.sv ----
// Port T pull and routing control and port S pin control, Wishbone slave.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ptsp_params.svh"

module ptsp_pin_ctrl
  import ptsp_pkg::*;
#(
  parameter int T_PINS     = `PTSP_T_PINS,
  parameter int ROUTE_BITS = `PTSP_T_ROUTE_BITS,
  parameter int S_PINS     = `PTSP_S_PINS,
  parameter int TX_PIN     = `PTSP_S_TX_PIN,
  parameter int RX_PIN     = `PTSP_S_RX_PIN
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire ptsp_wb_req_t          wbReq,
  output ptsp_wb_rsp_t               wbRsp,
  input  wire logic [T_PINS-1:0]     tGpioData,
  input  wire logic [T_PINS-1:0]     tGpioDirection,
  input  wire logic [T_PINS-1:0]     timerOutputActive,
  input  wire logic [T_PINS-1:0]     timerUnitOut,
  input  wire logic [ROUTE_BITS-1:0] pulseChannelEnable,
  input  wire logic [ROUTE_BITS-1:0] pulseUnitOut,
  output logic      [T_PINS-1:0]     tPinOut,
  output logic      [T_PINS-1:0]     tPinOeN,
  output logic      [T_PINS-1:0]     tPullUp,
  output logic      [T_PINS-1:0]     tPullDown,
  input  wire logic [S_PINS-1:0]     sPinIn,
  input  wire logic                  serialTxEnable,
  input  wire logic                  serialTxData,
  input  wire logic                  serialRxEnable,
  output logic      [S_PINS-1:0]     sPinOut,
  output logic      [S_PINS-1:0]     sPinOeN,
  output logic      [S_PINS-1:0]     sDriveReduced
);

  localparam int DW = `PTSP_WB_DATA_W;
  localparam int RW = `PTSP_REG_W;

  // Parameters the logic cannot serve are refused at elaboration.
  generate
    if (T_PINS < 1 || T_PINS > RW)
    begin : g_bad_t_pins
      $error("T_PINS must lie between 1 and the register width");
    end
    if (ROUTE_BITS < 1 || ROUTE_BITS > T_PINS)
    begin : g_bad_route
      $error("ROUTE_BITS must lie between 1 and T_PINS");
    end
    if (S_PINS < 2 || S_PINS > RW)
    begin : g_bad_s_pins
      $error("S_PINS must lie between 2 and the register width");
    end
    if (TX_PIN >= S_PINS || RX_PIN >= S_PINS || TX_PIN == RX_PIN)
    begin : g_bad_serial
      $error("Serial pins must be distinct port S pins");
    end
  endgenerate

  // Software-visible registers.
  logic [T_PINS-1:0]     tPullEnable_reg;
  logic [T_PINS-1:0]     tPullPolarity_reg;
  logic [ROUTE_BITS-1:0] tRouteSelect_reg;
  logic [S_PINS-1:0]     sDataLatch_reg;
  logic [S_PINS-1:0]     sDirection_reg;
  logic [S_PINS-1:0]     sDriveSelect_reg;

  // Bus slave state.
  logic                  ack_reg;
  logic [DW-1:0]         readData_reg;
  logic [DW-1:0]         readData_next;
  logic                  busActive;
  logic                  busWrite;
  ptsp_reg_t             regHit;
  logic [S_PINS-1:0]     sPinLevel;

  // Next values of the registered pin outputs.
  logic [T_PINS-1:0]     tPinOut_next;
  logic [T_PINS-1:0]     tPinOeN_next;
  logic [T_PINS-1:0]     tPullUp_next;
  logic [T_PINS-1:0]     tPullDown_next;
  logic [S_PINS-1:0]     sPinOut_next;
  logic [S_PINS-1:0]     sPinOeN_next;
  logic [S_PINS-1:0]     sDriveReduced_next;
  logic [S_PINS-1:0]     sDataRead;

  // Maps a byte address onto a register; used by both read and write.
  function automatic ptsp_reg_t decodeReg
  (
    input logic [`PTSP_WB_ADDR_W-1:0] adr
  );
    logic [3:0] index;
    index = adr[`PTSP_WB_ADDR_W-1:2];
    if (adr[1:0] != 2'h0)
    begin
      decodeReg = PTSP_REG_NONE;
    end
    else if (index == `PTSP_IDX_T_PULL_ENABLE)
    begin
      decodeReg = PTSP_REG_T_PULL_ENABLE;
    end
    else if (index == `PTSP_IDX_T_PULL_POLARITY)
    begin
      decodeReg = PTSP_REG_T_PULL_POLARITY;
    end
    else if (index == `PTSP_IDX_T_ROUTE_SELECT)
    begin
      decodeReg = PTSP_REG_T_ROUTE_SELECT;
    end
    else if (index == `PTSP_IDX_S_DATA)
    begin
      decodeReg = PTSP_REG_S_DATA;
    end
    else if (index == `PTSP_IDX_S_PIN_LEVEL)
    begin
      decodeReg = PTSP_REG_S_PIN_LEVEL;
    end
    else if (index == `PTSP_IDX_S_DIRECTION)
    begin
      decodeReg = PTSP_REG_S_DIRECTION;
    end
    else if (index == `PTSP_IDX_S_DRIVE_SELECT)
    begin
      decodeReg = PTSP_REG_S_DRIVE_SELECT;
    end
    else
    begin
      decodeReg = PTSP_REG_NONE;
    end
  endfunction : decodeReg

  // Pin levels come from outside the clock domain.
  ptsp_sync #(
    .WIDTH   (S_PINS)
  ) u_s_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .asyncIn (sPinIn),
    .syncOut (sPinLevel)
  );

  assign regHit    = decodeReg(wbReq.adr);
  assign busActive = wbReq.cyc & wbReq.stb;
  // The write lands on the edge at which the master samples ack.
  assign busWrite  = busActive & wbReq.we & ack_reg & wbReq.sel[0];

  // Every access is acknowledged one cycle after it is presented,
  // unmapped ones included, so the master never hangs.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= busActive & ~ack_reg;
    end
  end

  // Port T pull enable and polarity.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tPullEnable_reg   <= T_PINS'(`PTSP_RST_T_PULL_ENABLE);
      tPullPolarity_reg <= T_PINS'(`PTSP_RST_T_PULL_POLARITY);
    end
    else if (busWrite)
    begin
      if (regHit == PTSP_REG_T_PULL_ENABLE)
      begin
        tPullEnable_reg <= wbReq.dat[T_PINS-1:0];
      end
      if (regHit == PTSP_REG_T_PULL_POLARITY)
      begin
        tPullPolarity_reg <= wbReq.dat[T_PINS-1:0];
      end
    end
  end

  // Routing select. Setting a bit with no pulse channel behind it is
  // not trapped here; such a pin simply never sees an enabled channel.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tRouteSelect_reg <= ROUTE_BITS'(`PTSP_RST_T_ROUTE_SELECT);
    end
    else if (busWrite && regHit == PTSP_REG_T_ROUTE_SELECT)
    begin
      tRouteSelect_reg <= wbReq.dat[ROUTE_BITS-1:0];
    end
  end

  // Port S data latch, direction and drive select. The pin level
  // register has no storage, so a write to it changes nothing.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sDataLatch_reg   <= S_PINS'(`PTSP_RST_S_DATA);
      sDirection_reg   <= S_PINS'(`PTSP_RST_S_DIRECTION);
      sDriveSelect_reg <= S_PINS'(`PTSP_RST_S_DRIVE_SELECT);
    end
    else if (busWrite)
    begin
      if (regHit == PTSP_REG_S_DATA)
      begin
        sDataLatch_reg <= wbReq.dat[S_PINS-1:0];
      end
      if (regHit == PTSP_REG_S_DIRECTION)
      begin
        sDirection_reg <= wbReq.dat[S_PINS-1:0];
      end
      if (regHit == PTSP_REG_S_DRIVE_SELECT)
      begin
        sDriveSelect_reg <= wbReq.dat[S_PINS-1:0];
      end
    end
  end

  // Port T pin steering: pulse unit first, then timer, then GPIO.
  genvar ti;
  generate
    for (ti = 0; ti < T_PINS; ti++)
    begin : g_t_pin
      logic pulseDrives;
      logic pulseLevel;
      logic timerDrives;
      logic isOutput;
      if (ti < ROUTE_BITS)
      begin : g_routed
        assign pulseDrives = tRouteSelect_reg[ti]
                           & pulseChannelEnable[ti];
        assign pulseLevel  = pulseUnitOut[ti];
      end
      else
      begin : g_timer_only
        assign pulseDrives = 1'b0;
        assign pulseLevel  = 1'b0;
      end
      assign timerDrives = ~pulseDrives & timerOutputActive[ti];
      assign isOutput    = pulseDrives | timerDrives
                         | tGpioDirection[ti];
      assign tPinOut_next[ti] = pulseDrives ? pulseLevel
                              : timerDrives ? timerUnitOut[ti]
                              : tGpioData[ti];
      assign tPinOeN_next[ti] = ~isOutput;
      // A pull only acts on a pin that is not being driven.
      assign tPullUp_next[ti]   = tPullEnable_reg[ti] & ~isOutput
                                & ~tPullPolarity_reg[ti];
      assign tPullDown_next[ti] = tPullEnable_reg[ti] & ~isOutput
                                & tPullPolarity_reg[ti];
    end
  endgenerate

  // Port S pin steering with serial overrides on two pins.
  genvar si;
  generate
    for (si = 0; si < S_PINS; si++)
    begin : g_s_pin
      logic isOutput;
      logic txOwns;
      if (si == TX_PIN)
      begin : g_tx
        assign txOwns   = serialTxEnable;
        assign isOutput = serialTxEnable | sDirection_reg[si];
      end
      else if (si == RX_PIN)
      begin : g_rx
        assign txOwns   = 1'b0;
        assign isOutput = ~serialRxEnable & sDirection_reg[si];
      end
      else
      begin : g_plain
        assign txOwns   = 1'b0;
        assign isOutput = sDirection_reg[si];
      end
      assign sPinOut_next[si] = txOwns ? serialTxData : sDataLatch_reg[si];
      assign sPinOeN_next[si] = ~isOutput;
      assign sDriveReduced_next[si] = isOutput
                                    & sDriveSelect_reg[si];
      // The read follows the direction register, not the override.
      assign sDataRead[si] = sDirection_reg[si] ? sDataLatch_reg[si]
                                                : sPinLevel[si];
    end
  endgenerate

  // Read mux. Narrow registers are zero-extended to the bus width.
  always_comb
  begin
    readData_next = '0;
    if (regHit == PTSP_REG_T_PULL_ENABLE)
    begin
      readData_next[T_PINS-1:0] = tPullEnable_reg;
    end
    else if (regHit == PTSP_REG_T_PULL_POLARITY)
    begin
      readData_next[T_PINS-1:0] = tPullPolarity_reg;
    end
    else if (regHit == PTSP_REG_T_ROUTE_SELECT)
    begin
      readData_next[ROUTE_BITS-1:0] = tRouteSelect_reg;
    end
    else if (regHit == PTSP_REG_S_DATA)
    begin
      readData_next[S_PINS-1:0] = sDataRead;
    end
    else if (regHit == PTSP_REG_S_PIN_LEVEL)
    begin
      readData_next[S_PINS-1:0] = sPinLevel;
    end
    else if (regHit == PTSP_REG_S_DIRECTION)
    begin
      readData_next[S_PINS-1:0] = sDirection_reg;
    end
    else if (regHit == PTSP_REG_S_DRIVE_SELECT)
    begin
      readData_next[S_PINS-1:0] = sDriveSelect_reg;
    end
  end

  // Read data is captured as ack rises and cleared as ack falls, so the
  // bus shows zero in every cycle without an acknowledge.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      readData_reg <= '0;
    end
    else
    begin
      readData_reg <= (busActive && !ack_reg) ? readData_next : '0;
    end
  end

  assign wbRsp.ack = ack_reg;
  assign wbRsp.dat = readData_reg;

  // Pin outputs are registered so the pads see no decode glitches;
  // this costs one cycle from a register or module change to the pin.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tPinOut   <= '0;
      tPinOeN   <= '1;
      tPullUp   <= '0;
      tPullDown     <= '0;
      sPinOut       <= '0;
      sPinOeN       <= '1;
      sDriveReduced <= '0;
    end
    else
    begin
      tPinOut       <= tPinOut_next;
      tPinOeN       <= tPinOeN_next;
      tPullUp       <= tPullUp_next;
      tPullDown     <= tPullDown_next;
      sPinOut       <= sPinOut_next;
      sPinOeN       <= sPinOeN_next;
      sDriveReduced <= sDriveReduced_next;
    end
  end

endmodule : ptsp_pin_ctrl

// ---- hdl/ptsp_params.svh ----
// Register indices, reset values and widths for the port T/S pin control.
// Summary of operation
// - Port T pull enabled per bit, inputs only.
// - Pulls off after reset; ignored on outputs.
// - Polarity bit 0 selects pull-up.
// - Polarity bit 1 selects pull-down.
// - Routing bits pick timer or pulse unit.
// - Data read gives latch or pin by direction.
// - Pin level register always reads synced pins.
// - Writes to pin level register are ignored.
// - Direction bit 0 input, 1 output.
// - Serial transmit forces output, receive forces input.
// - Disabled serial channel returns direction to register.
// - Reads settle within three cycles after direction change.
// - Drive bit 1 selects reduced drive strength.
// - Drive select ignored on input pins.
// - Pulse, then timer, then general output drives pin.
// - Reads synchronous; pin levels pass synchronizers.
`ifndef PTSP_PARAMS_SVH
`define PTSP_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define PTSP_IDX_T_PULL_ENABLE   4'h4
`define PTSP_IDX_T_PULL_POLARITY 4'h5
`define PTSP_IDX_T_ROUTE_SELECT  4'h7
`define PTSP_IDX_S_DATA          4'h8
`define PTSP_IDX_S_PIN_LEVEL     4'h9
`define PTSP_IDX_S_DIRECTION     4'hA
`define PTSP_IDX_S_DRIVE_SELECT  4'hB

// Reset values.
`define PTSP_RST_T_PULL_ENABLE   8'h00
`define PTSP_RST_T_PULL_POLARITY 8'h00
`define PTSP_RST_T_ROUTE_SELECT  8'h00
`define PTSP_RST_S_DATA          8'h00
`define PTSP_RST_S_DIRECTION     8'h00
`define PTSP_RST_S_DRIVE_SELECT  8'h00

// Widths.
`define PTSP_WB_DATA_W           32
`define PTSP_WB_ADDR_W           6
`define PTSP_REG_W               8
`define PTSP_T_PINS              8
`define PTSP_T_ROUTE_BITS        5
`define PTSP_S_PINS              4
`define PTSP_S_TX_PIN            1
`define PTSP_S_RX_PIN            0
`define PTSP_SYNC_STAGES         2

`endif

// ---- hdl/ptsp_pkg.sv ----
// Types shared by the port T/S pin control files.
`include "ptsp_params.svh"

package ptsp_pkg;

  typedef struct packed {
    logic                          cyc;
    logic                          stb;
    logic                          we;
    logic [3:0]                    sel;
    logic [`PTSP_WB_ADDR_W-1:0]    adr;
    logic [`PTSP_WB_DATA_W-1:0]    dat;
  } ptsp_wb_req_t;

  typedef struct packed {
    logic                          ack;
    logic [`PTSP_WB_DATA_W-1:0]    dat;
  } ptsp_wb_rsp_t;

  typedef enum logic [2:0] {
    PTSP_REG_NONE,
    PTSP_REG_T_PULL_ENABLE,
    PTSP_REG_T_PULL_POLARITY,
    PTSP_REG_T_ROUTE_SELECT,
    PTSP_REG_S_DATA,
    PTSP_REG_S_PIN_LEVEL,
    PTSP_REG_S_DIRECTION,
    PTSP_REG_S_DRIVE_SELECT
  } ptsp_reg_t;

endpackage : ptsp_pkg

// ---- hdl/ptsp_sync.sv ----
// Two-stage synchronizer for asynchronous pin levels.
`timescale 1ns/1ps

module ptsp_sync
#(
  parameter int WIDTH = 4
)
(
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("ptsp_sync needs a width of at least one");
    end
  endgenerate

  // Only the second stage reads the first; nothing else may tap it.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule : ptsp_sync

// ---- tb/ptsp_pin_model.sv ----
// Pin-side model of port S: wire level from the block and outside drivers.
`timescale 1ns/1ps

module ptsp_pin_model
(
  input  wire logic [3:0] sPinOut,
  input  wire logic [3:0] sPinOeN,
  input  wire logic [3:0] extLevel,
  output logic      [3:0] sPinIn
);
  // A released pin shows the outside level, which the bench redraws each
  // step, so a stale block value can never pass for the pin.
  assign sPinIn = (~sPinOeN & sPinOut) | (sPinOeN & extLevel);
endmodule : ptsp_pin_model

// ---- tb/ptsp_pin_ctrl_sva.sv ----
// Checker of the port T/S pin control ports, bound to the design.
`timescale 1ns/1ps

module ptsp_pin_ctrl_chk
  import ptsp_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         nrst,
  input wire ptsp_wb_req_t wbReq,
  input wire ptsp_wb_rsp_t wbRsp,
  input wire logic [7:0]   tGpioDirection,
  input wire logic [7:0]   timerOutputActive,
  input wire logic [7:0]   timerUnitOut,
  input wire logic [7:0]   tPinOut,
  input wire logic [7:0]   tPinOeN,
  input wire logic [7:0]   tPullUp,
  input wire logic [7:0]   tPullDown,
  input wire logic         serialTxEnable,
  input wire logic         serialTxData,
  input wire logic         serialRxEnable,
  input wire logic [3:0]   sPinOut,
  input wire logic [3:0]   sPinOeN,
  input wire logic [3:0]   sDriveReduced
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire busReq = wbReq.cyc & wbReq.stb;

  a_ack_follows: assert property (busReq && !wbRsp.ack |=> wbRsp.ack)
    else $error("no ack after request");
  a_ack_single: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack longer than one cycle");
  a_idle_dat: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
    else $error("read data not zero when idle");
  a_upper_zero: assert property (wbRsp.ack && wbReq.adr[5]
    |-> wbRsp.dat[31:4] == 28'h0) else $error("upper bits not zero");
  a_pull_input: assert property (
    ((tPullUp | tPullDown) & ~tPinOeN) == 8'h0)
    else $error("pull active on output");
  a_pull_excl: assert property ((tPullUp & tPullDown) == 8'h0)
    else $error("both pulls on");
  a_drive_input: assert property ((sDriveReduced & sPinOeN) == 4'h0)
    else $error("reduced drive on input");
  a_tx_forced: assert property (serialTxEnable |=> !sPinOeN[1]
    && sPinOut[1] == $past(serialTxData)) else $error("transmit pin wrong");
  a_rx_forced: assert property (serialRxEnable |=> sPinOeN[0])
    else $error("receive pin not input");
  a_timer_pin: assert property (timerOutputActive[7] |=> !tPinOeN[7]
    && tPinOut[7] == $past(timerUnitOut[7])) else $error("timer pin wrong");
  a_gpio_dir: assert property (!timerOutputActive[7]
    |=> tPinOeN[7] == !$past(tGpioDirection[7])) else $error("gpio dir");

  c_tx_reduced: cover property (serialTxEnable && sDriveReduced[1]);
  c_pull_down: cover property (|tPullDown);
  c_read_ack: cover property (wbRsp.ack && !wbReq.we);
endmodule : ptsp_pin_ctrl_chk

bind ptsp_pin_ctrl ptsp_pin_ctrl_chk u_ptsp_pin_ctrl_chk (.clk_sys(clk_sys),
  .nrst(nrst), .wbReq(wbReq), .wbRsp(wbRsp), .tGpioDirection(tGpioDirection),
  .timerOutputActive(timerOutputActive), .timerUnitOut(timerUnitOut),
  .tPinOut(tPinOut), .tPinOeN(tPinOeN), .tPullUp(tPullUp),
  .tPullDown(tPullDown), .serialTxEnable(serialTxEnable),
  .serialTxData(serialTxData), .serialRxEnable(serialRxEnable),
  .sPinOut(sPinOut), .sPinOeN(sPinOeN), .sDriveReduced(sDriveReduced));

// ---- tb/ptsp_pin_ctrl_test.sv ----
// Self-checking bench of the port T/S pin control.
`timescale 1ns/1ps

module ptsp_pin_ctrl_test
  import ptsp_pkg::*;
();
  logic         clk_sys = 1'b0;
  logic         nrst = 1'b0;
  ptsp_wb_req_t wbReq = '0;
  ptsp_wb_rsp_t wbRsp;
  logic [7:0]   tGpioData = '0, tGpioDirection = '0;
  logic [7:0]   timerOutputActive = '0, timerUnitOut = '0;
  logic [4:0]   pulseChannelEnable = '0, pulseUnitOut = '0;
  logic [7:0]   tPinOut, tPinOeN, tPullUp, tPullDown;
  logic [3:0]   sPinIn, sPinOut, sPinOeN, sDriveReduced;
  logic [3:0]   extLevel = 4'hA;
  logic         serialTxEnable = 1'b0, serialTxData = 1'b0;
  logic         serialRxEnable = 1'b0;
  logic [7:0]   pe = '0, pol = '0, route = '0;
  logic [7:0]   sData = '0, sDir = '0, sDrv = '0;
  int           seed = 32'hbac1;
  int           miscompares = 0, checks_done = 0, cycles = 0;

  ptsp_pin_ctrl u_ptsp_pin_ctrl (.clk_sys(clk_sys), .nrst(nrst),
    .wbReq(wbReq), .wbRsp(wbRsp), .tGpioData(tGpioData),
    .tGpioDirection(tGpioDirection), .timerOutputActive(timerOutputActive),
    .timerUnitOut(timerUnitOut), .pulseChannelEnable(pulseChannelEnable),
    .pulseUnitOut(pulseUnitOut), .tPinOut(tPinOut), .tPinOeN(tPinOeN),
    .tPullUp(tPullUp), .tPullDown(tPullDown), .sPinIn(sPinIn),
    .serialTxEnable(serialTxEnable), .serialTxData(serialTxData),
    .serialRxEnable(serialRxEnable), .sPinOut(sPinOut), .sPinOeN(sPinOeN),
    .sDriveReduced(sDriveReduced));
  ptsp_pin_model u_ptsp_pin_model (.sPinOut(sPinOut), .sPinOeN(sPinOeN),
    .extLevel(extLevel), .sPinIn(sPinIn));

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [3:0] sEff();
    logic [3:0] d;
    d = sDir[3:0];
    if (serialTxEnable) d[1] = 1'b1;
    if (serialRxEnable) d[0] = 1'b0;
    return d;
  endfunction : sEff

  function automatic logic [3:0] sOut();
    logic [3:0] o;
    o = sData[3:0];
    if (serialTxEnable) o[1] = serialTxData;
    return o;
  endfunction : sOut

  function automatic logic [3:0] sWire();
    return (sEff() & sOut()) | (~sEff() & extLevel);
  endfunction : sWire

  function automatic logic [31:0] tExp();
    logic [7:0] pw, dr, o;
    pw = {3'h0, route[4:0] & pulseChannelEnable};
    dr = pw | timerOutputActive | tGpioDirection;
    o = (pw & {3'h0, pulseUnitOut}) | (~pw & timerOutputActive & timerUnitOut)
      | (~pw & ~timerOutputActive & tGpioData);
    return {~dr & pe & pol, ~dr & pe & ~pol, dr, o & dr};
  endfunction : tExp

  function automatic logic [31:0] expRd(input logic [5:0] a);
    case (a)
      6'h10: return {24'h0, pe};
      6'h14: return {24'h0, pol};
      6'h1C: return {27'h0, route[4:0]};
      6'h20: return {28'h0, (sDir[3:0] & sData[3:0]) | (~sDir[3:0] & sWire())};
      6'h24: return {28'h0, sWire()};
      6'h28: return {28'h0, sDir[3:0]};
      6'h2C: return {28'h0, sDrv[3:0]};
      default: return 32'h0;
    endcase
  endfunction : expRd

  function automatic logic [31:0] draw(input int n);
    // The first two steps are the all-ones and all-zeros corners.
    return n == 0 ? 32'hFFFFFFFF : n == 1 ? 32'h0 : $random(seed);
  endfunction : draw

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge clk_sys);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a,
               dat: {24'h0, d}};
    do @(posedge clk_sys); while (wbRsp.ack !== 1'b1);
    q = wbRsp.dat;
    wbReq <= '0;
  endtask : wb

  task automatic readAll();
    logic [5:0]  adrs [9] = '{6'h10, 6'h14, 6'h1C, 6'h20, 6'h24, 6'h28,
                              6'h2C, 6'h18, 6'h11};
    logic [31:0] q;
    foreach (adrs[i])
    begin
      wb(adrs[i], 1'b0, 8'h0, q);
      check(q, expRd(adrs[i]));
    end
  endtask : readAll

  task automatic conclude();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  initial
  begin
    logic [31:0] r, q;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    readAll();
    for (int n = 0; n < 40; n++)
    begin
      r = draw(n);
      pe = r[7:0];
      pol = r[15:8];
      route = r[23:16] & 8'hEF;
      sData = r[31:24];
      r = draw(n);
      sDir = r[7:0];
      sDrv = r[15:8];
      wb(6'h10, 1'b1, pe, q);
      wb(6'h14, 1'b1, pol, q);
      wb(6'h1C, 1'b1, route, q);
      wb(6'h20, 1'b1, sData, q);
      wb(6'h28, 1'b1, sDir, q);
      wb(6'h2C, 1'b1, sDrv, q);
      wb(6'h24, 1'b1, r[23:16], q);
      r = draw(n);
      tGpioData <= r[7:0];
      tGpioDirection <= r[15:8];
      timerOutputActive <= r[23:16];
      timerUnitOut <= r[31:24];
      r = draw(n);
      pulseChannelEnable <= r[4:0];
      pulseUnitOut <= r[9:5];
      extLevel <= r[13:10];
      serialTxEnable <= r[14];
      serialTxData <= r[15];
      serialRxEnable <= r[16];
      // Pin changes need both synchronizer stages plus the output register.
      repeat (4) @(posedge clk_sys);
      q = {tPullDown, tPullUp, ~tPinOeN, tPinOut & ~tPinOeN};
      check(q, tExp());
      q = {20'h0, sDriveReduced, ~sPinOeN, sPinOut & ~sPinOeN};
      r = {20'h0, sDrv[3:0] & sEff(), sEff(), sOut() & sEff()};
      check(q, r);
      readAll();
    end
    conclude();
  end
endmodule : ptsp_pin_ctrl_test
